// file: tb_watchdog_and_bus_timeout_monitor.sv
// Self-checking bench for the watchdog and bus timeout monitor.
`timescale 1ns/1ns
`default_nettype none
module tb_watchdog_and_bus_timeout_monitor
  import wdm_pkg::*;
;
  localparam int WB = 3;  // Shortened watchdog base exponent.
  localparam int PD = 4;  // Shortened prescaler ratio.
  logic              aclk, aresetn, iack_valid, iack_hit, wdt_irq7;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0]        s_axi_awprot, s_axi_arprot, iack_level;
  logic [31:0]       s_axi_wdata, s_axi_rdata;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic              s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic              s_axi_rready, reset_out, bus_cycle_active;
  logic              bus_cycle_internal, bus_cycle_ack, m_start, m_int;
  logic              bus_transfer_error;
  logic [7:0]        iack_vector;
  logic [11:0]       m_len;
  int                fails, comparisons;

  wdm_top #(.WDT_BASE(WB), .PRE_DIV(PD), .PULSE_LEN(2)) dut_u (.*);
  wdm_bus_model bus_u (.aclk(aclk), .aresetn(aresetn), .start(m_start),
    .internal(m_int), .len(m_len), .xfer_err(bus_transfer_error),
    .active(bus_cycle_active), .cyc_internal(bus_cycle_internal),
    .ack(bus_cycle_ack));

  // Clock of 100 ns period.
  always #50 aclk = ~aclk;

  // Compares one value and counts it.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
      begin
        fails++;
        $display("Error at %0t ns: saw %h, expected %h", $time, got, exp);
      end
  endtask

  // Checks that a measured count lies inside a window.
  task automatic win(input int n, input int lo, input int hi);
    chk(32'(n >= lo && n <= hi), 32'h1);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Selects the condition that a bounded wait looks for.
  function automatic logic sig(input int s);
    case (s)
      0: return wdt_irq7;
      1: return reset_out;
      2: return !reset_out;
      3: return iack_hit;
      4: return bus_transfer_error;
      default: return !bus_cycle_active;
    endcase
  endfunction

  // Waits a bounded time; an expired mandatory wait ends the run.
  task automatic wait_for(input int s, input int lim, input bit must,
                          output int n);
    for (n = 0; n < lim; n++)
    begin
      @(posedge aclk);
      if (sig(s))
        break;
    end
    if (must && n == lim)
    begin
      fails++;
      report_and_stop();
    end
  endtask

  // One register access; each channel is released on its own handshake.
  task automatic axi(input bit wr, input logic [9:0] idx,
                     input logic [7:0] d, output logic [31:0] rd,
                     output logic [1:0] rs);
    int n;
    @(posedge aclk);
    if (wr)
    begin
      s_axi_awaddr  <= {idx, 2'b00};
      s_axi_wdata   <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
    end
    else
    begin
      s_axi_araddr  <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
    end
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (wr ? s_axi_bvalid : s_axi_rvalid)
        break;
    end
    rd = s_axi_rdata;
    rs = wr ? s_axi_bresp : s_axi_rresp;
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    if (n == 50)
    begin
      fails++;
      report_and_stop();
    end
  endtask

  // Write and check the response code.
  task automatic wr(input logic [9:0] i, input logic [7:0] d,
                    input logic [1:0] er);
    logic [31:0] rd;
    logic [1:0]  rs;
    axi(1'b1, i, d, rd, rs);
    chk({30'h0, rs}, {30'h0, er});
  endtask

  // Read and check response and, when accepted, the data.
  task automatic rdc(input logic [9:0] i, input logic [7:0] e,
                     input logic [1:0] er);
    logic [31:0] rd;
    logic [1:0]  rs;
    axi(1'b0, i, 8'h00, rd, rs);
    chk({30'h0, rs}, {30'h0, er});
    if (er == RESP_OKAY)
      chk(rd, {24'h000000, e});
  endtask

  // System reset held for two clocks.
  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  // Acknowledges level 7 and checks the vector that comes back.
  task automatic ack_chk(input logic [7:0] e);
    int n;
    @(posedge aclk);
    iack_valid <= 1'b1;
    iack_level <= WDT_IRQ_LEVEL;
    @(posedge aclk);
    iack_valid <= 1'b0;
    wait_for(3, 4, 1'b1, n);
    chk({24'h0, iack_vector}, {24'h0, e});
  endtask

  // Runs one bus cycle and checks when the transfer error comes.
  task automatic bus(input bit in, input int len, input int lo,
                     input int hi);
    int n;
    @(posedge aclk);
    m_start <= 1'b1;
    m_int   <= in;
    m_len   <= 12'(len);
    @(posedge aclk);
    m_start <= 1'b0;
    wait_for(4, len + 20, 1'b0, n);
    win(n, lo, hi);
    wait_for(5, len + 20, 1'b1, n);
  endtask

  // Reset state, unmapped access and the bus monitor defaults.
  task automatic t_reset();
    do_reset();
    rdc(IDX_PROT_CTRL, PROT_CTRL_RESET, RESP_OKAY);
    rdc(IDX_WDT_VECTOR, 8'h00, RESP_OKAY);
    rdc(IDX_WDT_SERVICE, 8'h00, RESP_OKAY);
    rdc(10'h3FF, 8'h00, RESP_DECERR);
    wr(10'h3FF, 8'h5A, RESP_DECERR);
    bus(1'b0, 1100, 1120, 1120);
    bus(1'b1, 1100, 1020, 1028);
    chk({31'h0, wdt_irq7}, 32'h0);
    $display("Reset state test done");
  endtask

  // Write-once control, service sequence, acknowledge, bus timeout.
  task automatic t_service();
    do_reset();
    wr(IDX_WDT_VECTOR, 8'h42, RESP_OKAY);
    // A write without the low byte lane must not use up the one write.
    s_axi_wstrb <= 4'hE;
    wr(IDX_PROT_CTRL, 8'h01, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    wr(IDX_PROT_CTRL, 8'h8F, RESP_OKAY);
    rdc(IDX_PROT_CTRL, 8'h8F, RESP_OKAY);
    wr(IDX_PROT_CTRL, 8'h00, RESP_OKAY);
    rdc(IDX_PROT_CTRL, 8'h8F, RESP_OKAY);
    // Each round finishes well inside the 32-clock period.
    for (int i = 0; i < 6; i++)
    begin
      wr(IDX_WDT_SERVICE, SERVICE_ARM, RESP_OKAY);
      wr(IDX_WDT_SERVICE, 8'h12, RESP_OKAY);
      wr(IDX_WDT_SERVICE, SERVICE_DONE, RESP_OKAY);
    end
    chk({31'h0, wdt_irq7}, 32'h0);
    repeat (12) wr(IDX_WDT_SERVICE, SERVICE_ARM, RESP_OKAY);
    chk({31'h0, wdt_irq7}, 32'h1);
    rdc(IDX_WDT_VECTOR, 8'h00, RESP_OKAY);
    ack_chk(8'h42);
    bus(1'b0, 300, 124, 132);
    $display("Service test done");
  endtask

  // Every timing code with and without the prescaler.
  task automatic t_periods();
    int n;
    int t;
    for (int p = 0; p < 2; p++)
      for (int c = 0; c < 4; c++)
      begin
        do_reset();
        wr(IDX_PROT_CTRL, {2'b10, p[0], c[1:0], 3'b000}, RESP_OKAY);
        t = (1 << (WB + 2 * c)) * (p ? PD : 1);
        wait_for(0, t + 20, 1'b1, n);
        win(n, t - 6, t + 2);
        ack_chk(VECTOR_RESET);
      end
    $display("Timeout period test done");
  endtask

  // Reset mode: internal reset, then the flag and cleared control.
  task automatic t_rmode();
    int n;
    do_reset();
    wr(IDX_PROT_CTRL, 8'hC0, RESP_OKAY);
    wait_for(1, 40, 1'b1, n);
    chk({31'h0, wdt_irq7}, 32'h0);
    wait_for(2, 10, 1'b1, n);
    rdc(IDX_RESET_STATUS, 8'(1 << RS_WDT_FLAG), RESP_OKAY);
    wr(IDX_RESET_STATUS, 8'(1 << RS_WDT_FLAG), RESP_OKAY);
    rdc(IDX_RESET_STATUS, 8'h00, RESP_OKAY);
    rdc(IDX_PROT_CTRL, PROT_CTRL_RESET, RESP_OKAY);
    $display("Reset mode test done");
  endtask

  // Main sequence; inputs start quiet with reset asserted.
  initial
  begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_wdata} = '0;
    {s_axi_arvalid, s_axi_rready, iack_valid, iack_level} = '0;
    {m_start, m_int, m_len} = '0;
    s_axi_wstrb = 4'hF;
    fails = 0;
    comparisons = 0;
    t_reset();
    t_service();
    t_periods();
    t_rmode();
    report_and_stop();
  end
endmodule  // tb_watchdog_and_bus_timeout_monitor
`default_nettype wire

// file: wdm_bus_model.sv
// Behavioural bus master that runs one bus cycle at a time.
`timescale 1ns/1ns
`default_nettype none
module wdm_bus_model
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        start,     // Begin a cycle.
  input  wire logic        internal,  // Cycle targets on-chip space.
  input  wire logic [11:0] len,       // Clocks until the slave answers.
  input  wire logic        xfer_err,  // Transfer error from the monitor.
  output logic             active,
  output logic             cyc_internal,
  output logic             ack
);
  logic [11:0] cnt_reg;  // Clocks spent in the current cycle.

  // A slow slave may answer after the timeout; the error must end it.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      active       <= 1'b0;
      ack          <= 1'b0;
      cnt_reg      <= 12'h000;
      cyc_internal <= 1'b0;
    end
    else if (!active)
    begin
      // Idle qualifier toggles so a stale value is never trusted.
      active       <= start;
      cnt_reg      <= 12'h000;
      cyc_internal <= start ? internal : ~cyc_internal;
    end
    else if (ack || xfer_err)
    begin
      active <= 1'b0;
      ack    <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_reg + 12'h001;
      ack     <= (cnt_reg == len - 12'h001);
    end
  end
endmodule  // wdm_bus_model
`default_nettype wire

// file: wdm_bus_monitor.sv
// Bus cycle timeout monitor that flags cycles running too long.
`timescale 1ns/1ns
`default_nettype none
module wdm_bus_monitor
  import wdm_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       rst_n,
  input  wire logic       enable_ext,
  input  wire logic [1:0] timing,
  input  wire logic       cycle_active,
  input  wire logic       cycle_internal,
  input  wire logic       cycle_ack,
  output logic            transfer_error
);

  logic [BM_CNT_W-1:0] count_reg;   // Clocks spent in the current cycle.
  logic                fired_reg;   // Error already given for this cycle.
  logic [BM_CNT_W-1:0] last;        // Final clock of the allowed period.
  logic                watched;     // Current cycle is being timed.

  // Internal cycles are always timed; external ones only when enabled.
  assign watched = cycle_active && !cycle_ack &&
                   (cycle_internal || enable_ext);

  // The longest period is halved for each step of the code.
  assign last = BM_CNT_W'((BM_MAX_CLOCKS >> timing) - 1);

  // Count clocks of a watched cycle; restart whenever the cycle ends.
  always_ff @(posedge aclk)
  begin
    if (!rst_n || !watched)
    begin
      count_reg <= '0;
    end
    else if (count_reg != last)
    begin
      count_reg <= count_reg + 1'b1;
    end
  end

  // One error pulse per overlong cycle; it ends the cycle for the master.
  always_ff @(posedge aclk)
  begin
    if (!rst_n || !cycle_active)
    begin
      fired_reg      <= 1'b0;
      transfer_error <= 1'b0;
    end
    else
    begin
      // The pulse is registered so the master sees a clean level.
      transfer_error <= watched && !fired_reg && count_reg == last;
      if (watched && count_reg == last)
      begin
        fired_reg <= 1'b1;
      end
    end
  end

endmodule // wdm_bus_monitor
`default_nettype wire

// file: wdm_checker.sv
// Port-level checks for the watchdog and bus timeout monitor.
`timescale 1ns/1ns
`default_nettype none
module wdm_checker
  import wdm_pkg::*;
#(
  parameter int PULSE_LEN = RESET_OUT_CLKS // Reset-out pulse length.
)
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_arready,
  input wire logic        iack_valid,
  input wire logic [2:0]  iack_level,
  input wire logic        iack_hit,
  input wire logic        wdt_irq7,
  input wire logic        reset_out,
  input wire logic        bus_cycle_active,
  input wire logic        bus_cycle_ack,
  input wire logic        bus_transfer_error
);
  logic [11:0] act_cnt;  // Clocks of the current unanswered bus cycle.
  logic [7:0]  hi_cnt;   // Clocks that reset-out has been high.

  // Helper counters; tests keep cycles short, so no saturation is needed.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      act_cnt <= 12'h000;
      hi_cnt  <= 8'h00;
    end
    else
    begin
      act_cnt <= (bus_cycle_active && !bus_cycle_ack) ? act_cnt + 12'h001
                                                      : 12'h000;
      hi_cnt  <= reset_out ? hi_cnt + 8'h01 : 8'h00;
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("Write answer lost.");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("Read answer lost.");
  a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("Read taken while answer pending.");
  a_upper_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("Upper read bits not zero.");
  a_iack_cause: assert property (
    iack_hit |-> $past(iack_valid) && $past(iack_level) == WDT_IRQ_LEVEL &&
    $past(wdt_irq7))
    else $error("Acknowledge hit without cause.");
  a_iack_answer: assert property (
    iack_valid && iack_level == WDT_IRQ_LEVEL && wdt_irq7 |=> iack_hit)
    else $error("Acknowledge not answered.");
  a_err_pulse: assert property (
    bus_transfer_error |=> !bus_transfer_error)
    else $error("Transfer error longer than one clock.");
  a_err_late: assert property (
    bus_transfer_error |-> act_cnt >= 12'd126)
    else $error("Transfer error before shortest timeout.");
  a_pulse_len: assert property (
    $fell(reset_out) |-> hi_cnt == 8'(PULSE_LEN))
    else $error("Reset-out pulse has wrong length.");
endmodule  // wdm_checker

bind wdm_top wdm_checker #(.PULSE_LEN(PULSE_LEN)) u_chk (.*);
`default_nettype wire

// file: wdm_pkg.sv
// Shared constants for the watchdog and bus timeout monitor.
`default_nettype none
package wdm_pkg;

  // Register bus address width in bits.
  localparam int ADDR_W = 12;
  // Register indices; the byte address is four times the index.
  localparam logic [9:0] IDX_RESET_STATUS = 10'h000;
  localparam logic [9:0] IDX_PROT_CTRL    = 10'h003;
  localparam logic [9:0] IDX_WDT_VECTOR   = 10'h004;
  localparam logic [9:0] IDX_WDT_SERVICE  = 10'h043;

  // Field positions inside the protection control register.
  localparam int PC_WDT_EN    = 7;
  localparam int PC_RST_SEL   = 6;
  localparam int PC_PRESCALE  = 5;
  localparam int PC_WDT_TIME  = 3;
  localparam int PC_BM_EN     = 2;
  localparam int PC_BM_TIME   = 0;
  // Watchdog reset flag position inside the reset status register.
  localparam int RS_WDT_FLAG  = 5;

  // Reset values.
  localparam logic [7:0] PROT_CTRL_RESET = 8'h00;
  localparam logic [7:0] VECTOR_RESET    = 8'h0F;

  // Service sequence values.
  localparam logic [7:0] SERVICE_ARM  = 8'h55;
  localparam logic [7:0] SERVICE_DONE = 8'hAA;

  // Interrupt level raised by a watchdog expiry.
  localparam logic [2:0] WDT_IRQ_LEVEL = 3'h7;

  // Timing: watchdog period is 2^(base + step*code) ticks.
  localparam int WDT_BASE_LOG2   = 9;
  localparam int WDT_STEP_LOG2   = 2;
  localparam int PRESCALE_DIV    = 512;
  // Bus monitor period is BM_MAX_CLOCKS shifted right by the code.
  localparam int BM_MAX_CLOCKS   = 1024;
  localparam int BM_CNT_W        = 11;
  // Length of the reset-out pulse in clocks.
  localparam int RESET_OUT_CLKS  = 8;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Watchdog sequencing states.
  typedef enum logic [0:0] {WD_RUN, WD_RESET} wdm_state_e;

endpackage
`default_nettype wire

// file: wdm_top.sv
// Watchdog, protection control registers and bus monitor top level.
`timescale 1ns/1ns
`default_nettype none
module wdm_top
  import wdm_pkg::*;
#(
  parameter int WDT_BASE = WDT_BASE_LOG2,  // Log2 of shortest timeout.
  parameter int PRE_DIV  = PRESCALE_DIV,   // Prescaler divide ratio.
  parameter int PULSE_LEN = RESET_OUT_CLKS // Reset-out pulse length.
)
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              iack_valid,
  input  wire logic [2:0]        iack_level,
  output logic                   iack_hit,
  output logic [7:0]             iack_vector,
  output logic                   wdt_irq7,
  output logic                   reset_out,
  input  wire logic              bus_cycle_active,
  input  wire logic              bus_cycle_internal,
  input  wire logic              bus_cycle_ack,
  output logic                   bus_transfer_error
);

  // Counter width covers the longest unprescaled period.
  localparam int CNT_W = WDT_BASE + 3 * WDT_STEP_LOG2;
  localparam int PRE_W = $clog2(PRE_DIV);
  localparam int RST_W = $clog2(PULSE_LEN + 1);

  // Refuse settings the counters cannot serve.
  if (WDT_BASE < 1 || WDT_BASE > 24 || PRE_DIV < 2 || PULSE_LEN < 1)
  begin : g_bad_params
    $error("wdm_top: unsupported parameter values");
  end

  logic [ADDR_W-1:0] aw_addr_reg;   // Latched write address.
  logic              aw_held_reg;   // Write address waiting for data.
  logic [7:0]        w_data_reg;    // Latched low write byte.
  logic              w_lane_reg;    // Low byte lane was enabled.
  logic              w_held_reg;    // Write data waiting for address.
  logic              wr_fire;       // Both halves present: do the write.
  logic [9:0]        wr_idx;        // Index of the register written.
  logic              wr_byte;       // Write touches the low byte.
  logic [7:0]        prot_ctrl_reg; // Protection control contents.
  logic              locked_reg;    // Control register already written.
  logic [7:0]        vector_reg;    // Vector returned on acknowledge.
  logic              armed_reg;     // First half of service seen.
  logic              wdt_flag_reg;  // Last reset came from the watchdog.
  logic [PRE_W-1:0]  pre_reg;       // Prescaler count.
  logic [CNT_W-1:0]  wdt_cnt_reg;   // Watchdog tick count.
  logic [CNT_W-1:0]  wdt_last;      // Final tick of the period.
  logic              tick;          // Watchdog counter advances.
  logic              expire;        // Watchdog period ran out.
  logic              serviced;      // Valid sequence completed.
  logic              irq_reg;       // Pending level-7 request.
  logic              irq_take;      // Acknowledge consumes the request.
  wdm_state_e        state_reg;     // Run or reset pulse.
  logic [RST_W-1:0]  rst_cnt_reg;   // Clocks left of reset-out.
  logic              soft_done;     // Internal reset finishes now.
  logic              sys_rst_n;     // System or internal reset, low.
  logic              wdt_en;        // Decoded control fields.
  logic              rst_sel;
  logic              prescale;
  logic [1:0]        wdt_time;

  assign wdt_en   = prot_ctrl_reg[PC_WDT_EN];
  assign rst_sel  = prot_ctrl_reg[PC_RST_SEL];
  assign prescale = prot_ctrl_reg[PC_PRESCALE];
  assign wdt_time = prot_ctrl_reg[PC_WDT_TIME +: 2];

  // An internal reset re-initialises everything but the reset flag and the register bus channels.
  assign soft_done = state_reg == WD_RESET && rst_cnt_reg == '0;
  assign sys_rst_n = aresetn && !soft_done;

  // Write channel: address and data are taken independently.
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
  assign wr_fire       = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_idx        = aw_addr_reg[ADDR_W-1:2];
  assign wr_byte       = wr_fire && w_lane_reg;

  // Hold each write half until the pair is complete.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg  <= '0;
      w_lane_reg  <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      else if (wr_fire)
      begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata[7:0];
        w_lane_reg <= s_axi_wstrb[0];
      end
      else if (wr_fire)
      begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // Write response; unmapped addresses answer with a decode error.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      case (wr_idx)
        IDX_RESET_STATUS, IDX_PROT_CTRL,
        IDX_WDT_VECTOR, IDX_WDT_SERVICE: s_axi_bresp <= RESP_OKAY;
        default:                         s_axi_bresp <= RESP_DECERR;
      endcase
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control register takes only the first low-byte write after any reset.
  always_ff @(posedge aclk)
  begin
    if (!sys_rst_n)
    begin
      prot_ctrl_reg <= PROT_CTRL_RESET;
      locked_reg    <= 1'b0;
    end
    else if (wr_byte && wr_idx == IDX_PROT_CTRL && !locked_reg)
    begin
      prot_ctrl_reg <= w_data_reg;
      locked_reg    <= 1'b1;
    end
  end

  // Vector register; never read back over the bus.
  always_ff @(posedge aclk)
  begin
    if (!sys_rst_n)
    begin
      vector_reg <= VECTOR_RESET;
    end
    else if (wr_byte && wr_idx == IDX_WDT_VECTOR)
    begin
      vector_reg <= w_data_reg;
    end
  end

  // Service sequence: only the arm value followed by the done value
  // counts, and unrelated writes in between leave the arm in place.
  assign serviced = wr_byte && wr_idx == IDX_WDT_SERVICE &&
                    armed_reg && w_data_reg == SERVICE_DONE;
  always_ff @(posedge aclk)
  begin
    if (!sys_rst_n)
    begin
      armed_reg <= 1'b0;
    end
    else if (wr_byte && wr_idx == IDX_WDT_SERVICE)
    begin
      if (w_data_reg == SERVICE_ARM)
      begin
        armed_reg <= 1'b1;
      end
      else if (serviced)
      begin
        armed_reg <= 1'b0;
      end
    end
  end

  // Prescaler gives one tick every PRE_DIV clocks when selected.
  assign tick = !prescale || pre_reg == PRE_W'(PRE_DIV - 1);
  always_ff @(posedge aclk)
  begin
    if (!sys_rst_n || !wdt_en || !prescale || tick)
    begin
      pre_reg <= '0;
    end
    else
    begin
      pre_reg <= pre_reg + 1'b1;
    end
  end

  // Period in ticks is 2^(base + 2*code); prescaling makes each tick PRE_DIV clocks.
  assign wdt_last = CNT_W'((64'd1 << (WDT_BASE + WDT_STEP_LOG2 *
                    int'(wdt_time))) - 64'd1);
  assign expire   = wdt_en && state_reg == WD_RUN && tick &&
                    wdt_cnt_reg == wdt_last;

  // Watchdog counter; disabled means held at zero.
  always_ff @(posedge aclk)
  begin
    if (!sys_rst_n || !wdt_en || serviced || expire)
    begin
      wdt_cnt_reg <= '0;
    end
    else if (tick && state_reg == WD_RUN)
    begin
      wdt_cnt_reg <= wdt_cnt_reg + 1'b1;
    end
  end

  // Expiry either starts a reset pulse or raises the interrupt.
  always_ff @(posedge aclk)
  begin
    if (!sys_rst_n)
    begin
      state_reg   <= WD_RUN;
      rst_cnt_reg <= '0;
    end
    else
    begin
      case (state_reg)
        WD_RUN:
        begin
          if (expire && rst_sel)
          begin
            state_reg   <= WD_RESET;
            rst_cnt_reg <= RST_W'(PULSE_LEN - 1);
          end
        end
        WD_RESET:
        begin
          rst_cnt_reg <= rst_cnt_reg - 1'b1;
        end
        default:
        begin
          state_reg <= WD_RUN;
        end
      endcase
    end
  end

  // Reset-out is driven for the whole internal reset pulse.
  assign reset_out = state_reg == WD_RESET;

  // Interrupt request; a new expiry wins over an acknowledge clear.
  assign irq_take = iack_valid && iack_level == WDT_IRQ_LEVEL && irq_reg;
  always_ff @(posedge aclk)
  begin
    if (!sys_rst_n)
    begin
      irq_reg <= 1'b0;
    end
    else if (expire && !rst_sel)
    begin
      irq_reg <= 1'b1;
    end
    else if (irq_take)
    begin
      irq_reg <= 1'b0;
    end
  end
  assign wdt_irq7 = irq_reg;

  // Acknowledge answer: vector and hit strobe from flip-flops.
  always_ff @(posedge aclk)
  begin
    if (!sys_rst_n)
    begin
      iack_hit    <= 1'b0;
      iack_vector <= '0;
    end
    else
    begin
      iack_hit <= irq_take;
      if (irq_take)
      begin
        iack_vector <= vector_reg;
      end
    end
  end

  // Watchdog reset flag survives the internal reset it reports; the
  // setting event wins over a write-one clear in the same cycle.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wdt_flag_reg <= 1'b0;
    end
    else if (soft_done)
    begin
      wdt_flag_reg <= 1'b1;
    end
    else if (wr_byte && wr_idx == IDX_RESET_STATUS &&
             w_data_reg[RS_WDT_FLAG])
    begin
      wdt_flag_reg <= 1'b0;
    end
  end

  // Read channel; write-only registers read as zero.
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
      case (s_axi_araddr[ADDR_W-1:2])
        IDX_PROT_CTRL:    s_axi_rdata[7:0] <= prot_ctrl_reg;
        IDX_RESET_STATUS: s_axi_rdata[RS_WDT_FLAG] <= wdt_flag_reg;
        IDX_WDT_VECTOR, IDX_WDT_SERVICE: s_axi_rresp <= RESP_OKAY;
        default:          s_axi_rresp <= RESP_DECERR;
      endcase
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Bus timeout monitor for external and on-chip cycles.
  wdm_bus_monitor u_bus_monitor (
    .aclk           (aclk),
    .rst_n          (sys_rst_n),
    .enable_ext     (prot_ctrl_reg[PC_BM_EN]),
    .timing         (prot_ctrl_reg[PC_BM_TIME +: 2]),
    .cycle_active   (bus_cycle_active),
    .cycle_internal (bus_cycle_internal),
    .cycle_ack      (bus_cycle_ack),
    .transfer_error (bus_transfer_error)
  );

endmodule // wdm_top
`default_nettype wire
